// ===== common/mne_map.svh
// Purpose: Constants of the MAD noise estimator
// Assumes: Included by bare name from the package and estimator design files
// Notes:   Definitions only
`ifndef MNE_MAP_SVH
`define MNE_MAP_SVH

// ==========================================================
// Clock and sample timing
`define MNE_CLK_HZ        200000000
`define MNE_SAMPLE_HZ     512
`define MNE_TICK_CYCLES   (`MNE_CLK_HZ / `MNE_SAMPLE_HZ)

// ==========================================================
// Data path widths
`define MNE_DATA_W        16
`define MNE_NOISE_W       32
`define MNE_GAIN_W        22
`define MNE_GAIN_FRAC     12
`define MNE_SHIFT_MAX     28
`define MNE_TC_W          5
`define MNE_SHIFT_W       5

// ==========================================================
// Time constant table and settling
`define MNE_TC_COUNT      20
`define MNE_TC_RESET      5'h0A
`define MNE_SETTLE_SPANS  2
`define MNE_CNT_W         32

`endif

// ===== common/mne_pkg.sv
// Purpose: Types of the MAD noise estimator
// Assumes: Constants come from mne_map.svh
// Notes:   Nothing here is imported; users write mne_pkg::name
`include "mne_map.svh"
package mne_pkg;

  // ==========================================================
  // Sequencer states for one sample update
  typedef enum {
    MNE_IDLE,
    MNE_MEAN,
    MNE_DEV,
    MNE_MAD,
    MNE_SCALE
  } mne_state_e;

  // ==========================================================
  // Time constant index and averaging shift
  typedef logic [`MNE_TC_W-1:0]    mne_tc_t;
  typedef logic [`MNE_SHIFT_W-1:0] mne_shift_t;

endpackage

// ===== src/mne_ticker.sv
// Purpose: Fixed rate sample tick from the system clock
// Assumes: TICK_CYCLES clock cycles per sample
// Notes:   Tick is a one cycle pulse
`timescale 1ns/1ps
`default_nettype none
module mne_ticker #(
  parameter int TICK_CYCLES = 390625
) (
  input  wire logic mclk,
  input  wire logic srst,
  output logic      tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Parameter check
  if (TICK_CYCLES < 8) begin : g_bad
    $error("TICK_CYCLES must be at least 8");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_next;

  // Count down the sample period
  always_comb begin
    tick_next = 1'b0;
    cnt_next  = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    if (cnt_reg == '0) begin
      tick_next = 1'b1;
      cnt_next  = CW'(TICK_CYCLES - 1);
    end
  end

  // Register count and tick
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end

endmodule
`default_nettype wire

// ===== src/mne_avg.sv
// Purpose: Moving averager with span of 2**shift samples
// Assumes: Shift never exceeds SHIFT_MAX
// Notes:   Running sum form; mean is sum scaled down by the span
`timescale 1ns/1ps
`default_nettype none
module mne_avg #(
  parameter int IN_W      = 17,
  parameter int SHIFT_MAX = 28
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic                   clear,
  input  wire logic                   load,
  input  wire logic signed [IN_W-1:0] din,
  input  wire logic [4:0]             shift,
  output logic signed [IN_W-1:0]      mean
);

  localparam int ACC_W = IN_W + SHIFT_MAX + 1;

  if (IN_W < 2 || SHIFT_MAX > 31) begin : g_bad
    $error("mne_avg parameters out of range");
  end

  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] acc_next;
  logic signed [ACC_W-1:0] old_mean;
  logic signed [ACC_W-1:0] new_mean;
  logic signed [IN_W-1:0]  mean_next;

  // Add the new sample, remove one mean's worth
  always_comb begin
    old_mean = acc_reg >>> shift;
    acc_next = acc_reg;
    if (clear) begin
      acc_next = '0;
    end else if (load) begin
      acc_next = acc_reg + ACC_W'(din) - old_mean;
    end
    new_mean  = acc_next >>> shift;
    mean_next = new_mean[IN_W-1:0];
  end

  // Register sum and mean
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_reg <= '0;
      mean    <= '0;
    end else begin
      acc_reg <= acc_next;
      mean    <= mean_next;
    end
  end

endmodule
`default_nettype wire

// ===== src/mne_estimator.sv
// Purpose: MAD noise estimator for the X, Y and R streams
// Assumes: Inputs synchronous to mclk, sampled at each sample tick
// Notes:   Outputs scaled to volts per root hertz, Q12 gain
`timescale 1ns/1ps
`include "mne_map.svh"
`default_nettype none
module mne_estimator #(
  parameter int DATA_W      = `MNE_DATA_W,
  parameter int NOISE_W     = `MNE_NOISE_W,
  parameter int TICK_CYCLES = `MNE_TICK_CYCLES
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic signed [DATA_W-1:0] x_in,
  input  wire logic signed [DATA_W-1:0] y_in,
  input  wire logic signed [DATA_W-1:0] r_in,
  input  wire mne_pkg::mne_tc_t         tc_sel,
  input  wire logic                     sens_change,
  output logic [NOISE_W-1:0]            x_noise,
  output logic [NOISE_W-1:0]            y_noise,
  output logic [NOISE_W-1:0]            r_noise,
  output logic                          noise_valid,
  output logic                          noise_settled
);

  localparam int NCH    = 3;
  localparam int DEV_W  = DATA_W + 1;
  localparam int MAD_W  = DATA_W + 2;
  localparam int GAIN_W = `MNE_GAIN_W;
  localparam int PROD_W = DEV_W + GAIN_W;
  localparam int CNT_W  = `MNE_CNT_W;

  // ==========================================================
  // Parameter check
  if (DATA_W < 4 || NOISE_W < PROD_W - `MNE_GAIN_FRAC) begin : g_bad
    $error("mne_estimator widths cannot hold the scaled noise");
  end

  // ==========================================================
  // Time constant tables

  // Shift giving a span of 2**s samples, 10 to 20 tc
  function automatic mne_pkg::mne_shift_t tc_shift(
    input mne_pkg::mne_tc_t tc
  );
    case (tc)
      5'h00, 5'h01, 5'h02: tc_shift = 5'h00;
      5'h03:               tc_shift = 5'h01;
      5'h04:               tc_shift = 5'h03;
      5'h05:               tc_shift = 5'h04;
      5'h06:               tc_shift = 5'h06;
      5'h07:               tc_shift = 5'h08;
      5'h08:               tc_shift = 5'h09;
      5'h09:               tc_shift = 5'h0B;
      5'h0A:               tc_shift = 5'h0D;
      5'h0B:               tc_shift = 5'h0E;
      5'h0C:               tc_shift = 5'h10;
      5'h0D:               tc_shift = 5'h12;
      5'h0E:               tc_shift = 5'h13;
      5'h0F:               tc_shift = 5'h15;
      5'h10:               tc_shift = 5'h17;
      5'h11:               tc_shift = 5'h18;
      5'h12:               tc_shift = 5'h1A;
      default:             tc_shift = 5'h1C;
    endcase
  endfunction

  // Gaussian factor times root of inverse ENBW, Q12
  function automatic logic [GAIN_W-1:0] tc_gain(
    input mne_pkg::mne_tc_t tc
  );
    case (tc)
      5'h00:   tc_gain = 22'h000020;
      5'h01:   tc_gain = 22'h000038;
      5'h02:   tc_gain = 22'h000067;
      5'h03:   tc_gain = 22'h0000B2;
      5'h04:   tc_gain = 22'h000145;
      5'h05:   tc_gain = 22'h000232;
      5'h06:   tc_gain = 22'h000403;
      5'h07:   tc_gain = 22'h0006F2;
      5'h08:   tc_gain = 22'h000CAF;
      5'h09:   tc_gain = 22'h0015F7;
      5'h0A:   tc_gain = 22'h00281B;
      5'h0B:   tc_gain = 22'h004577;
      5'h0C:   tc_gain = 22'h007ED3;
      5'h0D:   tc_gain = 22'h00DBAA;
      5'h0E:   tc_gain = 22'h01910E;
      5'h0F:   tc_gain = 22'h02B6A4;
      5'h10:   tc_gain = 22'h04F440;
      5'h11:   tc_gain = 22'h0894A4;
      5'h12:   tc_gain = 22'h0FAA8C;
      default: tc_gain = 22'h1B2268;
    endcase
  endfunction

  // Absolute difference of sample and mean
  function automatic logic [DEV_W-1:0] abs_dev(
    input logic signed [DATA_W-1:0] s,
    input logic signed [DATA_W-1:0] m
  );
    logic signed [DEV_W-1:0] d;
    d = DEV_W'(s) - DEV_W'(m);
    abs_dev = d[DEV_W-1] ? DEV_W'(-d) : DEV_W'(d);
  endfunction

  // MAD times gain, Q12 fraction dropped
  function automatic logic [NOISE_W-1:0] scale(
    input logic signed [MAD_W-1:0] mad,
    input logic [GAIN_W-1:0]       gain
  );
    logic [PROD_W-1:0] p;
    p = PROD_W'(mad[DEV_W-1:0]) * PROD_W'(gain);
    scale = NOISE_W'(p >> `MNE_GAIN_FRAC);
  endfunction

  // ==========================================================
  // Sample tick
  logic tick;

  mne_ticker #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_ticker (
    .mclk (mclk),
    .srst (srst),
    .tick (tick)
  );

  // ==========================================================
  // Time constant tracking
  mne_pkg::mne_tc_t    tc_reg;
  mne_pkg::mne_tc_t    tc_next;
  mne_pkg::mne_shift_t shift_reg;
  mne_pkg::mne_shift_t shift_next;
  logic [GAIN_W-1:0]   gain_reg;
  logic [GAIN_W-1:0]   gain_next;
  logic                tc_changed;

  // Pick span and scale whenever the time constant moves
  always_comb begin
    tc_changed = (tc_sel != tc_reg);
    tc_next    = tc_sel;
    shift_next = tc_shift(tc_sel);
    gain_next  = tc_gain(tc_sel);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tc_reg    <= `MNE_TC_RESET;
      shift_reg <= tc_shift(`MNE_TC_RESET);
      gain_reg  <= tc_gain(`MNE_TC_RESET);
    end else begin
      tc_reg    <= tc_next;
      shift_reg <= shift_next;
      gain_reg  <= gain_next;
    end
  end

  // ==========================================================
  // Update sequencer
  mne_pkg::mne_state_e     state_reg;
  mne_pkg::mne_state_e     state_next;
  logic signed [DATA_W-1:0] samp_reg [NCH];
  logic signed [DATA_W-1:0] samp_next [NCH];
  logic [DEV_W-1:0]         dev_reg [NCH];
  logic [DEV_W-1:0]         dev_next [NCH];
  logic [NOISE_W-1:0]       noise_reg [NCH];
  logic [NOISE_W-1:0]       noise_next [NCH];
  logic                     valid_next;
  logic                     mean_load;
  logic                     mad_load;
  logic signed [DATA_W-1:0] mean_q [NCH];
  logic signed [MAD_W-1:0]  mad_q [NCH];

  // Tick, mean, deviation, MAD, scale; runs every sample
  always_comb begin
    state_next = state_reg;
    samp_next  = samp_reg;
    dev_next   = dev_reg;
    noise_next = noise_reg;
    valid_next = 1'b0;
    mean_load  = 1'b0;
    mad_load   = 1'b0;
    case (state_reg)
      mne_pkg::MNE_IDLE: begin
        if (tick) begin
          samp_next[0] = x_in;
          samp_next[1] = y_in;
          samp_next[2] = r_in;
          state_next   = mne_pkg::MNE_MEAN;
        end
      end
      mne_pkg::MNE_MEAN: begin
        mean_load  = 1'b1;
        state_next = mne_pkg::MNE_DEV;
      end
      mne_pkg::MNE_DEV: begin
        for (int c = 0; c < NCH; c++) begin
          dev_next[c] = abs_dev(samp_reg[c], mean_q[c]);
        end
        state_next = mne_pkg::MNE_MAD;
      end
      mne_pkg::MNE_MAD: begin
        mad_load   = 1'b1;
        state_next = mne_pkg::MNE_SCALE;
      end
      mne_pkg::MNE_SCALE: begin
        for (int c = 0; c < NCH; c++) begin
          noise_next[c] = scale(mad_q[c], gain_reg);
        end
        valid_next = 1'b1;
        state_next = mne_pkg::MNE_IDLE;
      end
      default: begin
        state_next = mne_pkg::MNE_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg   <= mne_pkg::MNE_IDLE;
      noise_valid <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        samp_reg[c]  <= '0;
        dev_reg[c]   <= '0;
        noise_reg[c] <= '0;
      end
    end else begin
      state_reg   <= state_next;
      noise_valid <= valid_next;
      samp_reg    <= samp_next;
      dev_reg     <= dev_next;
      noise_reg   <= noise_next;
    end
  end

  // ==========================================================
  // Averagers, one mean and one MAD per quantity
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    mne_avg #(
      .IN_W      (DATA_W),
      .SHIFT_MAX (`MNE_SHIFT_MAX)
    ) u_mean (
      .mclk  (mclk),
      .srst  (srst),
      .clear (tc_changed),
      .load  (mean_load),
      .din   (samp_reg[c]),
      .shift (shift_reg),
      .mean  (mean_q[c])
    );

    mne_avg #(
      .IN_W      (MAD_W),
      .SHIFT_MAX (`MNE_SHIFT_MAX)
    ) u_mad (
      .mclk  (mclk),
      .srst  (srst),
      .clear (tc_changed),
      .load  (mad_load),
      .din   (MAD_W'(dev_reg[c])),
      .shift (shift_reg),
      .mean  (mad_q[c])
    );
  end

  assign x_noise = noise_reg[0];
  assign y_noise = noise_reg[1];
  assign r_noise = noise_reg[2];

  // ==========================================================
  // Settling tracker
  logic [CNT_W-1:0] settle_reg;
  logic [CNT_W-1:0] settle_next;
  logic [CNT_W-1:0] settle_goal;
  logic             settled_next;

  // Restart on tc or sensitivity change; averagers clear on tc change only
  always_comb begin
    settle_goal = CNT_W'(`MNE_SETTLE_SPANS) << shift_reg;
    settle_next = settle_reg;
    if (tc_changed || sens_change) begin
      settle_next = '0;
    end else if (valid_next && settle_reg < settle_goal) begin
      settle_next = settle_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    settled_next = (settle_next >= settle_goal);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      settle_reg    <= '0;
      noise_settled <= 1'b0;
    end else begin
      settle_reg    <= settle_next;
      noise_settled <= settled_next;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/mne_estimator_props.sv
// Purpose: Port assertions for the noise estimator
// Assumes: One clock domain, synchronous reset srst
// Notes:   Bound to every mne_estimator instance
`timescale 1ns/1ps
`default_nettype none
module mne_estimator_props #(
  parameter int DATA_W      = 16,
  parameter int NOISE_W     = 32,
  parameter int TICK_CYCLES = 16
) (
  input wire logic                     mclk,
  input wire logic                     srst,
  input wire logic signed [DATA_W-1:0] x_in,
  input wire logic signed [DATA_W-1:0] y_in,
  input wire logic signed [DATA_W-1:0] r_in,
  input wire mne_pkg::mne_tc_t         tc_sel,
  input wire logic                     sens_change,
  input wire logic [NOISE_W-1:0]       x_noise,
  input wire logic [NOISE_W-1:0]       y_noise,
  input wire logic [NOISE_W-1:0]       r_noise,
  input wire logic                     noise_valid,
  input wire logic                     noise_settled
);
  // ==========================================================
  // Cycles since the last update
  logic [31:0] gap_reg;
  logic [31:0] gap_next;
  logic        seen_reg;
  logic        seen_next;

  // Next gap count and first-update flag
  always_comb begin
    gap_next  = noise_valid ? 32'h0 : gap_reg + 32'h1;
    seen_next = seen_reg | noise_valid;
  end

  // Register helpers
  always_ff @(posedge mclk) begin
    if (srst) begin
      gap_reg  <= 32'h0;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= gap_next;
      seen_reg <= seen_next;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_valid_pulse: assert property (
    noise_valid |=> !noise_valid) else $error("valid wider than one");
  a_valid_period: assert property (
    noise_valid && seen_reg |-> gap_reg == 32'(TICK_CYCLES - 1))
    else $error("update period wrong");
  a_out_hold: assert property (
    !noise_valid |-> $stable({x_noise, y_noise, r_noise}))
    else $error("noise moved without valid");
  a_tc_unsettle: assert property (
    $changed(tc_sel) |=> !noise_settled) else $error("tc kept settled");
  a_sens_unsettle: assert property (
    sens_change |=> !noise_settled) else $error("sens kept settled");
  a_settle_rise: assert property (
    $rose(noise_settled) |-> noise_valid) else $error("settle off update");
  a_settle_fall: assert property (
    $fell(noise_settled) |->
      $past(sens_change) || $past(tc_sel) != $past(tc_sel, 2))
    else $error("settled fell without cause");
  a_reset_clear: assert property (disable iff (1'b0)
    srst |=> !noise_valid && !noise_settled && x_noise == '0 &&
      y_noise == '0 && r_noise == '0) else $error("reset not clean");
endmodule
bind mne_estimator mne_estimator_props #(
  .DATA_W(DATA_W), .NOISE_W(NOISE_W), .TICK_CYCLES(TICK_CYCLES)
) mne_estimator_props_inst (
  .mclk(mclk), .srst(srst), .x_in(x_in), .y_in(y_in), .r_in(r_in),
  .tc_sel(tc_sel), .sens_change(sens_change), .x_noise(x_noise),
  .y_noise(y_noise), .r_noise(r_noise), .noise_valid(noise_valid),
  .noise_settled(noise_settled)
);
`default_nettype wire

// ===== testbench/mne_demod_model.sv
// Purpose: Demodulator output stage feeding X, Y, R samples
// Assumes: TICK matches the estimator sample period
// Notes:   Mode 1 makes X alternate sign between samples
`timescale 1ns/1ps
`default_nettype none
module mne_demod_model #(
  parameter int TICK = 16
) (
  input  wire logic          mclk,
  input  wire logic [1:0]    mode,
  output logic signed [15:0] x_out,
  output logic signed [15:0] y_out,
  output logic signed [15:0] r_out
);
  int   cnt = 0;
  logic ph  = 1'b0;

  // Flip phase once per sample period, off the sampling edge
  always @(negedge mclk) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    if (cnt == TICK - 1) ph <= ~ph;
  end

  // Sample values; Y and R stay fixed so their noise is zero
  always_comb begin
    x_out = (mode == 2'h1 && ph) ? -16'sh03E8 : 16'sh03E8;
    y_out = -16'sh01F4;
    r_out = 16'sh012C;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_mne_estimator.sv
// Purpose: Self-checking bench for the noise estimator
// Assumes: Short sample period of 16 clocks
// Notes:   Inputs driven at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_mne_estimator;
  localparam int TICK = 16;
  logic              mclk;
  logic              srst;
  logic signed [15:0] x_in;
  logic signed [15:0] y_in;
  logic signed [15:0] r_in;
  mne_pkg::mne_tc_t  tc_sel;
  logic              sens_change;
  logic [1:0]        mode;
  logic [31:0]       x_noise;
  logic [31:0]       y_noise;
  logic [31:0]       r_noise;
  logic [31:0]       held;
  logic              noise_valid;
  logic              noise_settled;
  int                n_errors = 0;
  int                total_checks = 0;

  mne_demod_model #(.TICK(TICK)) mne_demod_model_inst (
    .mclk(mclk), .mode(mode), .x_out(x_in), .y_out(y_in), .r_out(r_in));
  mne_estimator #(.TICK_CYCLES(TICK)) mne_estimator_inst (
    .mclk(mclk), .srst(srst), .x_in(x_in), .y_in(y_in), .r_in(r_in),
    .tc_sel(tc_sel), .sens_change(sens_change), .x_noise(x_noise),
    .y_noise(y_noise), .r_noise(r_noise), .noise_valid(noise_valid),
    .noise_settled(noise_settled));

  // ==========================================================
  // Clock and checking helpers
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_valid();
    int k;
    k = 0;
    @(negedge mclk);
    while (noise_valid !== 1'b1 && k < 64) begin
      @(negedge mclk);
      k++;
    end
    chk_flag(noise_valid, 1'b1);
  endtask

  task automatic settle_chk(input int goal);
    for (int i = 1; i <= goal; i++) begin
      wait_valid();
      chk_flag(noise_settled, i == goal);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    chk_word(x_noise | y_noise | r_noise, 32'h0);
    chk_flag(noise_settled, 1'b0);
    $display("done reset");
  endtask

  task automatic t_period();
    int k;
    wait_valid();
    k = 0;
    do begin
      @(negedge mclk);
      k++;
      if (k == 1) chk_flag(noise_valid, 1'b0);
    end while (noise_valid !== 1'b1 && k < 64);
    chk_word(32'(k), 32'(TICK));
    $display("done period");
  endtask

  task automatic t_const();
    repeat (300) wait_valid();
    chk_word(x_noise, 32'h0);
    chk_word(y_noise, 32'h0);
    chk_word(r_noise, 32'h0);
    $display("done constant");
  endtask

  task automatic t_square();
    mode = 2'h1;
    repeat (100) wait_valid();
    chk_flag(x_noise != 32'h0, 1'b1);
    chk_word(y_noise | r_noise, 32'h0);
    $display("done square");
  endtask

  task automatic t_tc();
    tc_sel = 5'h03;
    @(negedge mclk);
    chk_flag(noise_settled, 1'b0);
    // Cleared averagers, span 2, sample 1000: MAD 250, gain 0xB2
    wait_valid();
    chk_word(x_noise, 32'h0000000A);
    chk_flag(noise_settled, 1'b0);
    settle_chk(3);
    $display("done time constant");
  endtask

  task automatic t_sens();
    held = x_noise;
    sens_change = 1'b1;
    @(negedge mclk);
    sens_change = 1'b0;
    chk_flag(noise_settled, 1'b0);
    chk_word(x_noise, held);
    settle_chk(4);
    $display("done sensitivity");
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    srst = 1'b1;
    tc_sel = 5'h04;
    sens_change = 1'b0;
    mode = 2'h0;
    t_reset();
    t_period();
    t_const();
    t_square();
    t_tc();
    t_sens();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
